// ---- hdl/kwi_top.v ----
// The implementer's own choices: strobed register access and the placing of the registers.
`include "kwi_regs.vh"

// Operation
// - Edge mode: a valid edge on an enabled input sets the event flag.
// - Edge-and-level mode: valid edge or held asserted level sets the flag.
// - Interrupt request while flag set and irq enable bit 1 is one.
// - Event flag at status bit 3, read-only.
// - Writing one to bit 2 clears the flag; bit 2 reads zero.
// - Level mode: acknowledge clears only when all enabled inputs deasserted.
// - Status bit 0 selects mode: 0 edges only, 1 edges and levels.
// - Pin enable bits 3:0 include each input in detection.
// - Polarity bits 3:0: 0 falling/low, 1 rising/high.
// - Falling edge is a one sample followed by a zero sample.
// - Rising edge is a zero sample followed by a one sample.
// - Input must be seen deasserted before an edge is accepted.
// - Polarity bit picks pullup (0) or pulldown (1) when pull enabled.
// - Status bits 7:4 always read zero.
// - Port A pins 3:0 map onto enable and polarity bits 3:0.
// - In light sleep, enabled input wakes processor asynchronously; here WAKE_REQ is registered on REF_CLK and also needs irq enable bit 1.
// - In deep sleep block disabled and returns in reset state.
module kwi_top (
  input wire REF_CLK,
  input wire RSTN,
  input wire [`KWI_ADDR_W-1:0] ADDR,
  input wire [`KWI_DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`KWI_DATA_W-1:0] RDATA,
  input wire [`KWI_NPINS-1:0] KEY_INPUT_PIN,
  input wire LIGHT_SLEEP_MODE,
  input wire DEEP_SLEEP_MODE,
  output reg KEY_IRQ,
  output reg WAKE_REQ,
  output reg [`KWI_NPINS-1:0] PULL_DOWN_SEL
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n;

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Deep sleep holds the block in reset so it wakes in reset state
  assign rst_n = rst_s2_r & ~DEEP_SLEEP_MODE;

  // ****************************************
  // Decode
  // ****************************************
  function sel;
    input [`KWI_ADDR_W-1:0] a;
    input [`KWI_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [`KWI_NPINS-1:0] pin_enable_bits_r;
  reg [`KWI_NPINS-1:0] pin_polarity_bits_r;
  reg detect_mode_select_r;
  reg key_irq_enable_r;
  reg key_event_flag_r;
  reg key_event_flag_nxt;

  wire wr_sc;
  wire ack_wr;
  assign wr_sc = WR & sel(ADDR, `KWI_OFS_STATUS_CONTROL);
  assign ack_wr = wr_sc & WDATA[`KWI_BIT_ACK];

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_enable_bits_r <= `KWI_RST_PINS;
      pin_polarity_bits_r <= `KWI_RST_PINS;
      detect_mode_select_r <= `KWI_RST_BIT;
      key_irq_enable_r <= `KWI_RST_BIT;
    end else begin
      if (wr_sc) begin
        detect_mode_select_r <= WDATA[`KWI_BIT_MODE];
        key_irq_enable_r <= WDATA[`KWI_BIT_IRQ_EN];
      end
      if (WR && sel(ADDR, `KWI_OFS_PIN_ENABLE))
        pin_enable_bits_r <= WDATA[`KWI_NPINS-1:0];
      if (WR && sel(ADDR, `KWI_OFS_POLARITY))
        pin_polarity_bits_r <= WDATA[`KWI_NPINS-1:0];
    end
  end

  // ****************************************
  // Pin synchronisers and detection
  // ****************************************
  wire [`KWI_NPINS-1:0] pin_s;
  reg [`KWI_NPINS-1:0] pin_prev_r;
  // Armed once the pin has been seen at its deasserted level
  reg [`KWI_NPINS-1:0] armed_r;
  wire [`KWI_NPINS-1:0] asserted;
  wire [`KWI_NPINS-1:0] edge_hit;
  wire [`KWI_NPINS-1:0] level_hit;

  genvar i;
  generate
    for (i = 0; i < `KWI_NPINS; i = i + 1) begin : g_pin
      kwi_sync u_sync (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .d(KEY_INPUT_PIN[i]),
        .q(pin_s[i])
      );
      // Polarity 0: low asserted; 1: high asserted
      assign asserted[i] = pin_s[i] ~^ pin_polarity_bits_r[i];
      // Previous sample deasserted, current asserted
      assign edge_hit[i] = pin_enable_bits_r[i] & armed_r[i] &
        ((pin_prev_r[i] ^ pin_polarity_bits_r[i]) == 1'b1) &
        asserted[i];
      assign level_hit[i] = pin_enable_bits_r[i] & asserted[i];
    end
  endgenerate

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_r <= `KWI_RST_PINS;
      armed_r <= `KWI_RST_PINS;
    end else begin
      pin_prev_r <= pin_s;
      // Disabled pins lose arming so enabling needs a fresh deasserted view
      armed_r <= pin_enable_bits_r & (armed_r | ~asserted);
    end
  end

  wire any_edge;
  wire any_level;
  wire event_now;
  assign any_edge = |edge_hit;
  assign any_level = |level_hit;
  assign event_now = any_edge | (detect_mode_select_r & any_level);

  // ****************************************
  // Event flag
  // ****************************************
  always @* begin
    key_event_flag_nxt = key_event_flag_r;
    // Level mode blocks the clear while any enabled pin is asserted
    if (ack_wr && !(detect_mode_select_r && any_level))
      key_event_flag_nxt = 1'b0;
    if (event_now)
      key_event_flag_nxt = 1'b1;
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n)
      key_event_flag_r <= `KWI_RST_BIT;
    else
      key_event_flag_r <= key_event_flag_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire [`KWI_DATA_W-1:0] sc_read;
  assign sc_read = {4'h0, key_event_flag_r, 1'b0, key_irq_enable_r,
    detect_mode_select_r};

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= `KWI_RST_RDATA;
      KEY_IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
      PULL_DOWN_SEL <= `KWI_RST_PINS;
    end else begin
      RDATA <= `KWI_RST_RDATA;
      if (RD) begin
        if (sel(ADDR, `KWI_OFS_STATUS_CONTROL))
          RDATA <= sc_read;
        else if (sel(ADDR, `KWI_OFS_PIN_ENABLE))
          RDATA <= {4'h0, pin_enable_bits_r};
        else if (sel(ADDR, `KWI_OFS_POLARITY))
          RDATA <= {4'h0, pin_polarity_bits_r};
      end
      KEY_IRQ <= key_event_flag_nxt & key_irq_enable_r;
      // Registered wake request; the clock is assumed running here
      WAKE_REQ <= LIGHT_SLEEP_MODE & key_irq_enable_r &
        (|(pin_enable_bits_r & (KEY_INPUT_PIN ~^ pin_polarity_bits_r)));
      PULL_DOWN_SEL <= pin_polarity_bits_r;
    end
  end
endmodule

// ---- hdl/kwi_regs.vh ----
`ifndef KWI_REGS_VH
`define KWI_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define KWI_ADDR_W 2
`define KWI_OFS_STATUS_CONTROL 2'h0
`define KWI_OFS_PIN_ENABLE 2'h1
`define KWI_OFS_POLARITY 2'h2

// ****************************************
// Status/control fields
// ****************************************
`define KWI_BIT_MODE 0
`define KWI_BIT_IRQ_EN 1
`define KWI_BIT_ACK 2
`define KWI_BIT_FLAG 3

// ****************************************
// Widths and reset values
// ****************************************
`define KWI_NPINS 4
`define KWI_DATA_W 8
`define KWI_RST_PINS 4'h0
`define KWI_RST_BIT 1'b0
`define KWI_RST_RDATA 8'h00

`endif

// ---- hdl/kwi_sync.v ----
// ****************************************
// Two-stage level synchroniser
// ****************************************
module kwi_sync (
  input wire clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- bench/kwi_keys.sv ----
// ****
// Switch bank on the key inputs
// ****
module kwi_keys (
  input logic clk,
  input logic [3:0] press,
  input logic [3:0] pol,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released keys rest at the pulled idle level, never floating
  always @(posedge clk) pins <= ~(press ^ pol);
endmodule

// ---- bench/kwi_checker.sv ----
// ****
// Port checker
// ****
module kwi_chk (
  input logic REF_CLK,
  input logic RSTN,
  input logic [1:0] ADDR,
  input logic [7:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [7:0] RDATA,
  input logic [3:0] KEY_INPUT_PIN,
  input logic LIGHT_SLEEP_MODE,
  input logic DEEP_SLEEP_MODE,
  input logic KEY_IRQ,
  input logic WAKE_REQ,
  input logic [3:0] PULL_DOWN_SEL
);
  logic ie_r, act;
  logic [3:0] en_r, pol_r;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || DEEP_SLEEP_MODE);
  // Shadow of the control bits, fed only by the bus
  always_ff @(posedge REF_CLK or negedge RSTN or posedge DEEP_SLEEP_MODE)
    if (!RSTN || DEEP_SLEEP_MODE) begin
      ie_r <= 1'b0;
      en_r <= 4'h0;
      pol_r <= 4'h0;
    end else if (WR) begin
      if (ADDR == 2'h0) ie_r <= WDATA[1];
      if (ADDR == 2'h1) en_r <= WDATA[3:0];
      if (ADDR == 2'h2) pol_r <= WDATA[3:0];
    end
  assign act = LIGHT_SLEEP_MODE && ie_r && |(en_r & ~(KEY_INPUT_PIN ^ pol_r));
  sequence s_rd(a); RD && ADDR == a; endsequence
  property p_irq_en; KEY_IRQ |-> ie_r || $past(ie_r); endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq unmasked");
  property p_irq_hold; KEY_IRQ && ie_r && !(WR && ADDR == 2'h0) |=> KEY_IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_flag_rd; s_rd(2'h0) ##0 KEY_IRQ |=> RDATA[3]; endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag bit");
  property p_stat_hi; s_rd(2'h0) |=> RDATA[7:4] == 4'h0; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("upper bits");
  property p_ack_zero; s_rd(2'h0) |=> !RDATA[2]; endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack bit");
  property p_ie_rd; s_rd(2'h0) |=> RDATA[1] == $past(ie_r); endproperty
  a_ie_rd: assert property (p_ie_rd) else $error("enable bit");
  property p_pull; WR && ADDR == 2'h2 |-> ##2 PULL_DOWN_SEL == pol_r;
  endproperty
  a_pull: assert property (p_pull) else $error("pull select");
  property p_wake; WAKE_REQ == $past(act); endproperty
  a_wake: assert property (p_wake) else $error("wake request");
endmodule
bind kwi_top kwi_chk chk (.*);

// ---- bench/test_keypad_wake_interrupt.sv ----
// ****
// Testbench
// ****
module test_keypad_wake_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, ls = 0, ds = 0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [3:0] press = 4'h0, pol = 4'h0, pins, pull;
  logic irq, wake;
  int fails = 0, comparisons = 0;
  // Enable, polarity, pressed keys, {irq enable, flag, 00}
  logic [15:0] rows [5] = '{16'h101C, 16'h222C, 16'h4444,
    16'h808C, 16'h1028};
  kwi_keys keys (.clk(clk), .press(press), .pol(pol), .pins(pins));
  kwi_top dut (.REF_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .KEY_INPUT_PIN(pins),
    .LIGHT_SLEEP_MODE(ls), .DEEP_SLEEP_MODE(ds), .KEY_IRQ(irq),
    .WAKE_REQ(wake), .PULL_DOWN_SEL(pull));
  initial forever #5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
    @(posedge clk);
  endtask
  task automatic run_row(input logic [15:0] r);
    wr_reg(2'h0, 8'h00);
    pol <= r[11:8];
    wr_reg(2'h2, {4'h0, r[11:8]});
    wr_reg(2'h1, {4'h0, r[15:12]});
    cyc(4);
    wr_reg(2'h0, 8'h04);
    wr_reg(2'h0, {6'h0, r[3], 1'b0});
    press <= r[7:4];
    cyc(5);
    chk("irq", {7'h0, r[3] & r[2]}, {7'h0, irq});
    chk("wake", {7'h0, r[3] & r[2]}, {7'h0, wake});
    rd_chk(2'h0, {4'h0, r[2], 1'b0, r[3], 1'b0});
    press <= 4'h0;
    cyc(4);
    wr_reg(2'h0, {4'h0, 2'b11, r[3], 1'b0});
    rd_chk(2'h0, {6'h0, r[3], 1'b0});
    chk("pull", {4'h0, r[11:8]}, {4'h0, pull});
    $display("row done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    ls <= 1'b1;
    cyc(3);
    for (int a = 0; a < 3; a++) rd_chk(a[1:0], 8'h00);
    foreach (rows[r]) run_row(rows[r]);
    wr_reg(2'h1, 8'h00);
    press <= 4'h1;
    cyc(4);
    wr_reg(2'h1, 8'h01);
    cyc(4);
    wr_reg(2'h0, 8'h04);
    rd_chk(2'h0, 8'h00);
    wr_reg(2'h0, 8'h01);
    cyc(4);
    rd_chk(2'h0, 8'h09);
    wr_reg(2'h0, 8'h05);
    rd_chk(2'h0, 8'h09);
    press <= 4'h0;
    cyc(4);
    wr_reg(2'h0, 8'h05);
    rd_chk(2'h0, 8'h01);
    wr_reg(2'h0, 8'h00);
    press <= 4'h1;
    cyc(3);
    wr_reg(2'h0, 8'h04);
    rd_chk(2'h0, 8'h08);
    press <= 4'h0;
    cyc(4);
    wr_reg(2'h0, 8'h04);
    rd_chk(2'h0, 8'h00);
    wr_reg(2'h3, 8'hFF);
    rd_chk(2'h3, 8'h00);
    rd_chk(2'h1, 8'h01);
    ds <= 1'b1;
    cyc(2);
    ds <= 1'b0;
    cyc(3);
    rd_chk(2'h0, 8'h00);
    rd_chk(2'h1, 8'h00);
    $display("hand tests done");
    end_of_test();
  end
endmodule
